// ### logic/sgw_pkg.sv
// Shared constants and types for the store gather and write policy block
package sgw_pkg;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned LINE_W   = 64;
  localparam int unsigned LINE_LSB = 3;
  localparam int unsigned HALF_BIT = 2;
  localparam int unsigned TAG_W    = ADDR_W - LINE_LSB;
  localparam int unsigned KIND_W   = 5;
  localparam logic [3:0]  WORD_BE  = 4'hF;
  localparam logic [7:0]  LINE_BE  = 8'hFF;
  localparam logic [2:0]  LINE_OFS = 3'h0;
  // Register byte addresses
  localparam logic [31:0] CFG_OFS  = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] MCNT_OFS = 32'h0000_0008;
  localparam int unsigned CFG_SGE_BIT = 0;
  localparam int unsigned CFG_SNP_BIT = 1;
  localparam logic [1:0]  CFG_RST     = 2'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_EVICT = 5'h02,
    ST_READ  = 5'h04,
    ST_WRITE = 5'h08,
    ST_SNOOP = 5'h10
  } sgw_state_e;
  // Kind bits: byte-reverse, reservation, ext control, table search, fp
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0]        be;
    logic              ci;
    logic              wt;
    logic              grd;
    logic [KIND_W-1:0] kind;
  } sgw_ent_s;
endpackage

// ### logic/sgw_gather_if.sv
// Carrier between the store queue and the gather decision logic
`timescale 1ns/1ps
interface sgw_gather_if;
  sgw_pkg::sgw_ent_s e0;
  sgw_pkg::sgw_ent_s e1;
  logic              v1;
  logic              store_gather_enable;
  logic              merge;
  logic [63:0]       mdata;
  logic [7:0]        mbe;
  logic [31:0]       maddr;
  modport gat (input e0, e1, v1, store_gather_enable, output merge, mdata, mbe, maddr);
  modport load_store_unit (output e0, e1, v1, store_gather_enable, input merge, mdata, mbe, maddr);
endinterface

// ### logic/sgw_gather.sv
// Gather decision and double word merge for two queued stores
`timescale 1ns/1ps
module sgw_gather (
  sgw_gather_if.gat g
);
  // Candidate test: aligned full word, nonguarded, WT or CI, no excluded kind
  function automatic logic qual(input sgw_pkg::sgw_ent_s e);
    qual = (e.be == sgw_pkg::WORD_BE) && (e.addr[sgw_pkg::HALF_BIT-1:0] == '0)
        && (e.ci || e.wt) && !e.grd && (e.kind == '0);
  endfunction

  // Same double word, opposite halves; order of the two does not matter
  wire same_dw  = g.e0.addr[31:sgw_pkg::LINE_LSB] == g.e1.addr[31:sgw_pkg::LINE_LSB];
  wire diff_hw  = g.e0.addr[sgw_pkg::HALF_BIT] != g.e1.addr[sgw_pkg::HALF_BIT];
  wire both_q   = qual(g.e0) && qual(g.e1); // R1 R7
  wire same_att = g.e0.ci == g.e1.ci;
  // R3 R5 R15
  assign g.merge = g.store_gather_enable && g.v1 && both_q && same_att && same_dw && diff_hw;
  assign g.maddr = {g.e0.addr[31:sgw_pkg::LINE_LSB], sgw_pkg::LINE_OFS};
  assign g.mbe   = sgw_pkg::LINE_BE; // R15

  // Lanes placed by address bit only, so both endian modes gather alike
  for (genvar k = 0; k < 2; k++)
  begin : g_lane
    localparam logic LB = (k == 1);
    // R4 R6
    assign g.mdata[32*k +: 32] = (g.e0.addr[sgw_pkg::HALF_BIT] == LB) ? g.e0.data : g.e1.data;
  end
endmodule

// ### logic/sgw_regs.sv
// AXI4-Lite slave holding configuration, reading back status and merge count
`timescale 1ns/1ps
module sgw_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] stat,
  input  wire logic [31:0] mcnt,
  output logic             cfg_sge,
  output logic             cfg_snp
);
  logic [31:0] aa_q;
  logic [31:0] wd_q;
  logic        ws_q;
  logic        awh_q;
  logic        wh_q;
  logic [1:0]  cfg_q;

  // Write address and data are held independently, written once both are in
  wire aw_ok  = awvalid && awready;
  wire w_ok   = wvalid && wready;
  wire do_wr  = awh_q && wh_q && !bvalid;
  wire awh_d  = (awh_q || aw_ok) && !do_wr;
  wire wh_d   = (wh_q || w_ok) && !do_wr;
  wire bv_d   = do_wr || (bvalid && !bready);
  wire wa_cfg = aa_q == sgw_pkg::CFG_OFS;
  wire wa_ok  = wa_cfg || aa_q == sgw_pkg::STAT_OFS || aa_q == sgw_pkg::MCNT_OFS;
  wire ar_ok  = arvalid && arready;
  wire rv_d   = ar_ok || (rvalid && !rready);
  wire ra_cfg = araddr == sgw_pkg::CFG_OFS;
  wire ra_st  = araddr == sgw_pkg::STAT_OFS;
  wire ra_mc  = araddr == sgw_pkg::MCNT_OFS;
  wire [31:0] rd_mux = ra_cfg ? {30'h0, cfg_q} : ra_st ? stat : ra_mc ? mcnt : 32'h0;

  assign cfg_sge = cfg_q[sgw_pkg::CFG_SGE_BIT];
  assign cfg_snp = cfg_q[sgw_pkg::CFG_SNP_BIT];

  // Write channel; read-only registers accept and ignore writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {awh_q, wh_q, bvalid, ws_q} <= 4'h0;
      {awready, wready} <= 2'h3;
      aa_q  <= 32'h0;
      wd_q  <= 32'h0;
      bresp <= sgw_pkg::RESP_OKAY;
      cfg_q <= sgw_pkg::CFG_RST;
    end
    else
    begin
      awh_q   <= awh_d;
      wh_q    <= wh_d;
      bvalid  <= bv_d;
      awready <= !awh_d && !bv_d;
      wready  <= !wh_d && !bv_d;
      if (aw_ok) aa_q <= awaddr;
      if (w_ok) wd_q <= wdata;
      if (w_ok) ws_q <= wstrb[0];
      if (do_wr) bresp <= wa_ok ? sgw_pkg::RESP_OKAY : sgw_pkg::RESP_SLVERR;
      if (do_wr && wa_cfg && ws_q) cfg_q <= wd_q[1:0]; // R5
    end
  end

  // Read channel, data captured when the address is taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata   <= 32'h0;
      rresp   <= sgw_pkg::RESP_OKAY;
    end
    else
    begin
      rvalid  <= rv_d;
      arready <= !rv_d;
      if (ar_ok) rdata <= rd_mux;
      if (ar_ok) rresp <= (ra_cfg || ra_st || ra_mc) ? sgw_pkg::RESP_OKAY : sgw_pkg::RESP_SLVERR;
    end
  end
endmodule

// ### logic/sgw_top.sv
// Store queue, write policy, small data cache and snoop copy-back control
`timescale 1ns/1ps
// Function
// R1 - Only aligned nonguarded WT/CI words may gather
// R2 - Two gathered words leave as one beat
// R3 - Merge only two stores queued together
// R4 - Address order of the pair is irrelevant
// R5 - Gathering only while enable bit set
// R6 - Same gathering in both endian modes
// R7 - Excluded store kinds are never merged
// R8 - Software separates must-split stores with barrier
// R9 - Caching-inhibited accesses never allocate lines
// R10 - Inhibited hit: copy back dirty, then invalidate
// R11 - Write-through store updates cache and bus
// R12 - Write-back updates memory only on eviction/snoop
// R13 - Snooped dirty line held until copied back
// R14 - Load miss waits for pending stores
// R15 - Merge needs same double word, both halves
module sgw_top #(
  parameter int unsigned NLINES = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        st_valid,
  output logic             st_ready,
  input  wire logic [31:0] st_addr,
  input  wire logic [31:0] st_data,
  input  wire logic [3:0]  st_be,
  input  wire logic        st_ci,
  input  wire logic        st_wt,
  input  wire logic        st_grd,
  input  wire logic [4:0]  st_kind,
  input  wire logic        ld_valid,
  input  wire logic [31:0] ld_addr,
  input  wire logic        ld_ci,
  output logic             ld_done,
  output logic [31:0]      ld_data,
  output logic             bus_valid,
  input  wire logic        bus_ready,
  output logic             bus_we,
  output logic [31:0]      bus_addr,
  output logic [63:0]      bus_wdata,
  output logic [7:0]       bus_be,
  input  wire logic        bus_rvalid,
  input  wire logic [63:0] bus_rdata,
  input  wire logic        snp_valid,
  input  wire logic [31:0] snp_addr,
  output logic             snp_hold
);
  localparam int unsigned IW = $clog2(NLINES);
  localparam int unsigned LL = sgw_pkg::LINE_LSB;
  localparam int unsigned HB = sgw_pkg::HALF_BIT;

  // Index slicing needs a power of two with at least two lines
  if (NLINES < 2 || (NLINES & (NLINES - 1)) != 0)
  begin : g_bad_nlines
    $error("NLINES must be a power of two of at least 2");
  end

  function automatic logic [63:0] put_bytes(input logic [63:0] old,
                                            input logic [63:0] nw,
                                            input logic [7:0]  be);
    put_bytes = old;
    for (int i = 0; i < 8; i++)
      if (be[i]) put_bytes[8*i +: 8] = nw[8*i +: 8];
  endfunction

  sgw_pkg::sgw_ent_s   q0_q;
  sgw_pkg::sgw_ent_s   q1_q;
  sgw_pkg::sgw_ent_s   q0_d;
  sgw_pkg::sgw_ent_s   q1_d;
  sgw_pkg::sgw_state_e st_q;
  sgw_pkg::sgw_state_e aft_q;
  logic [1:0]          cnt_q;
  logic [1:0]          cnt_d;
  logic [28:0]         tag_q [NLINES];
  logic [63:0]         dat_q [NLINES];
  logic [NLINES-1:0]   val_q;
  logic [NLINES-1:0]   mod_q;
  logic [IW-1:0]       ev_idx_q;
  logic [31:0]         mcnt_q;
  logic                op_merge_q;
  logic                ld_op_q;
  logic                ld_ci_q;
  logic                cfg_sge;
  logic                cfg_snp;
  logic                c_we;
  logic [IW-1:0]       c_idx;
  logic [28:0]         c_tag;
  logic [63:0]         c_dat;
  logic                c_val;
  logic                c_mod;

  sgw_gather_if gif ();
  assign gif.e0  = q0_q;
  assign gif.e1  = q1_q;
  assign gif.v1  = cnt_q == 2'h2; // R3
  assign gif.store_gather_enable = cfg_sge;       // R5

  sgw_gather u_gather (
    .g (gif.gat)
  );

  // Store operand: merged pair in idle, else the pair choice latched at issue
  wire           is_idle = st_q == sgw_pkg::ST_IDLE;
  wire           use_m   = is_idle ? gif.merge : op_merge_q;
  wire [31:0]    op_addr = use_m ? gif.maddr : q0_q.addr;
  wire [63:0]    op_data = use_m ? gif.mdata : {q0_q.data, q0_q.data};
  wire [7:0]     s_be    = q0_q.addr[HB] ? {q0_q.be, 4'h0} : {4'h0, q0_q.be};
  wire [7:0]     op_be   = use_m ? gif.mbe : s_be;
  wire [IW-1:0]  op_idx  = op_addr[LL +: IW];
  wire           op_hit  = val_q[op_idx] && tag_q[op_idx] == op_addr[31:LL];
  wire           idx_drt = val_q[op_idx] && mod_q[op_idx];
  wire           st_wb   = !q0_q.ci && !q0_q.wt;
  wire [31:0]    op_line = {op_addr[31:LL], sgw_pkg::LINE_OFS};

  // Load and snoop lookups
  wire [IW-1:0]  ld_idx  = ld_addr[LL +: IW];
  wire           ld_hit  = val_q[ld_idx] && tag_q[ld_idx] == ld_addr[31:LL];
  wire           ld_drt  = val_q[ld_idx] && mod_q[ld_idx];
  wire [31:0]    ld_line = {ld_addr[31:LL], sgw_pkg::LINE_OFS};
  wire [63:0]    ld_lv   = dat_q[ld_idx];
  wire [IW-1:0]  sn_idx  = snp_addr[LL +: IW];
  wire           sn_tag  = tag_q[sn_idx] == snp_addr[31:LL];
  wire           sn_hit  = cfg_snp && snp_valid && val_q[sn_idx] && mod_q[sn_idx] && sn_tag;

  // Idle decisions: snoop first, then stores, then a load once stores drain.
  // Holding even load hits behind queued stores avoids reading stale words.
  wire go_snp = is_idle && sn_hit && !snp_hold;
  wire go_st  = is_idle && !go_snp && cnt_q != 2'h0;
  wire go_ld  = is_idle && !go_snp && ld_valid && !ld_done && cnt_q == 2'h0; // R14
  wire go_ldh = go_ld && !ld_ci && ld_hit;
  wire go_ldm = go_ld && !go_ldh;
  wire wb_hit = go_st && st_wb && op_hit;                        // R12
  wire st_ev  = st_wb ? !op_hit && idx_drt : q0_q.ci && op_hit && mod_q[op_idx]; // R10
  wire ld_ev  = ld_ci ? ld_hit && mod_q[ld_idx] : ld_drt;
  wire bus_dn = bus_valid && bus_ready;
  wire rd_dn  = st_q == sgw_pkg::ST_READ && !bus_valid && bus_rvalid;
  wire wr_dn  = st_q == sgw_pkg::ST_WRITE && bus_dn;
  wire pop2   = wr_dn && op_merge_q;
  wire pop1   = (wr_dn && !op_merge_q) || wb_hit || (rd_dn && !ld_op_q);
  wire push   = st_valid && st_ready;

  // Single cache write port shared by every update path
  always_comb
  begin
    c_we  = 1'b0;
    c_idx = op_idx;
    c_tag = op_addr[31:LL];
    c_dat = put_bytes(dat_q[op_idx], op_data, op_be);
    c_val = 1'b1;
    c_mod = 1'b0;
    if (go_st && q0_q.ci && op_hit && !mod_q[op_idx])
    begin
      c_we  = 1'b1; // R9 R10
      c_val = 1'b0;
    end
    else if (go_st && q0_q.wt && op_hit)
      c_we = 1'b1;  // R11
    else if (wb_hit)
    begin
      c_we  = 1'b1; // R12
      c_mod = 1'b1;
    end
    else if (go_ldm && ld_ci && ld_hit && !mod_q[ld_idx])
    begin
      c_we  = 1'b1; // R10
      c_idx = ld_idx;
      c_val = 1'b0;
    end
    else if ((st_q == sgw_pkg::ST_EVICT || st_q == sgw_pkg::ST_SNOOP) && bus_dn)
    begin
      c_we  = 1'b1;
      c_idx = ev_idx_q;
      c_tag = tag_q[ev_idx_q];
      c_dat = dat_q[ev_idx_q];
      c_val = st_q == sgw_pkg::ST_SNOOP; // R10 R13
    end
    else if (rd_dn && !ld_op_q)
    begin
      c_we  = 1'b1; // R12
      c_dat = put_bytes(bus_rdata, op_data, op_be);
      c_mod = 1'b1;
    end
    else if (rd_dn && !ld_ci_q)
    begin
      c_we  = 1'b1; // R9
      c_idx = ld_idx;
      c_tag = ld_addr[31:LL];
      c_dat = bus_rdata;
    end
  end

  // Cache state; data and tags need no reset behind the valid bits
  always_ff @(posedge ref_clk)
  begin
    if (c_we) tag_q[c_idx] <= c_tag;
    if (c_we) dat_q[c_idx] <= c_dat;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      val_q <= '0;
      mod_q <= '0;
    end
    else if (c_we)
    begin
      val_q[c_idx] <= c_val;
      mod_q[c_idx] <= c_mod;
    end
  end

  // Two-entry store queue: pop first, then append behind what remains
  always_comb
  begin
    q0_d  = q0_q;
    q1_d  = q1_q;
    cnt_d = cnt_q;
    if (pop2)
      cnt_d = 2'h0;
    else if (pop1)
    begin
      q0_d  = q1_q;
      cnt_d = cnt_q - 2'h1;
    end
    if (push)
    begin
      if (cnt_d == 2'h0) q0_d = {st_addr, st_data, st_be, st_ci, st_wt, st_grd, st_kind};
      else q1_d = {st_addr, st_data, st_be, st_ci, st_wt, st_grd, st_kind};
      cnt_d = cnt_d + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q0_q     <= '0;
      q1_q     <= '0;
      cnt_q    <= 2'h0;
      st_ready <= 1'b1;
      mcnt_q   <= 32'h0;
    end
    else
    begin
      q0_q     <= q0_d;
      q1_q     <= q1_d;
      cnt_q    <= cnt_d;
      st_ready <= cnt_d != 2'h2;
      if (pop2) mcnt_q <= mcnt_q + 32'h1;
    end
  end

  // Bus sequencer: one request outstanding, eviction runs ahead of its cause
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= sgw_pkg::ST_IDLE;
      aft_q      <= sgw_pkg::ST_IDLE;
      {bus_valid, bus_we, snp_hold, ld_done} <= 4'h0;
      bus_addr   <= 32'h0;
      bus_wdata  <= 64'h0;
      bus_be     <= 8'h0;
      ld_data    <= 32'h0;
      {op_merge_q, ld_op_q, ld_ci_q} <= 3'h0;
      ev_idx_q   <= '0;
    end
    else
    begin
      ld_done <= 1'b0;
      unique case (st_q)
        sgw_pkg::ST_IDLE:
        begin
          if (go_snp)
          begin
            {bus_valid, bus_we, snp_hold} <= 3'h7; // R13
            bus_addr  <= {tag_q[sn_idx], sgw_pkg::LINE_OFS};
            bus_wdata <= dat_q[sn_idx];
            bus_be    <= sgw_pkg::LINE_BE;
            ev_idx_q  <= sn_idx;
            st_q      <= sgw_pkg::ST_SNOOP;
          end
          else if (go_st && !wb_hit)
          begin
            op_merge_q <= gif.merge;
            ld_op_q    <= 1'b0;
            bus_valid  <= 1'b1;
            bus_we     <= st_ev || !st_wb;
            bus_addr   <= st_ev ? {tag_q[op_idx], sgw_pkg::LINE_OFS} : st_wb ? op_line : op_addr;
            bus_wdata  <= st_ev ? dat_q[op_idx] : op_data; // R2 R11
            bus_be     <= st_ev ? sgw_pkg::LINE_BE : op_be;
            ev_idx_q   <= op_idx;
            aft_q      <= st_wb ? sgw_pkg::ST_READ : sgw_pkg::ST_WRITE;
            st_q       <= st_ev ? sgw_pkg::ST_EVICT : st_wb ? sgw_pkg::ST_READ : sgw_pkg::ST_WRITE;
          end
          else if (go_ldh)
          begin
            ld_done <= 1'b1;
            ld_data <= ld_addr[HB] ? ld_lv[63:32] : ld_lv[31:0];
          end
          else if (go_ldm)
          begin
            {ld_op_q, bus_valid} <= 2'h3;
            ld_ci_q   <= ld_ci;
            bus_we    <= ld_ev;
            bus_addr  <= ld_ev ? {tag_q[ld_idx], sgw_pkg::LINE_OFS} : ld_line;
            bus_wdata <= ld_lv;
            bus_be    <= sgw_pkg::LINE_BE;
            ev_idx_q  <= ld_idx;
            aft_q     <= sgw_pkg::ST_READ;
            st_q      <= ld_ev ? sgw_pkg::ST_EVICT : sgw_pkg::ST_READ;
          end
        end
        sgw_pkg::ST_EVICT:
        begin
          if (bus_dn)
          begin
            bus_we    <= aft_q == sgw_pkg::ST_WRITE;
            bus_addr  <= ld_op_q ? ld_line : aft_q == sgw_pkg::ST_WRITE ? op_addr : op_line;
            bus_wdata <= op_data;
            bus_be    <= op_be;
            st_q      <= aft_q;
          end
        end
        sgw_pkg::ST_WRITE:
        begin
          if (bus_dn) bus_valid <= 1'b0;
          if (bus_dn) st_q <= sgw_pkg::ST_IDLE;
        end
        sgw_pkg::ST_READ:
        begin
          if (bus_dn) bus_valid <= 1'b0;
          if (rd_dn) st_q <= sgw_pkg::ST_IDLE;
          if (rd_dn) ld_done <= ld_op_q;
          if (rd_dn) ld_data <= ld_addr[HB] ? bus_rdata[63:32] : bus_rdata[31:0];
        end
        sgw_pkg::ST_SNOOP:
        begin
          if (bus_dn) {bus_valid, snp_hold} <= 2'h0;
          if (bus_dn) st_q <= sgw_pkg::ST_IDLE;
        end
        default: st_q <= sgw_pkg::ST_IDLE;
      endcase
    end
  end

  sgw_regs u_regs (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .stat    ({25'h0, st_q, cnt_q}),
    .mcnt    (mcnt_q),
    .cfg_sge (cfg_sge),
    .cfg_snp (cfg_snp)
  );

  // Checks on the policy behaviour
  a_merge_needs_en: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    gif.merge |-> cfg_sge) else $error("merge without enable");
  a_merge_two_q: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    gif.merge |-> cnt_q == 2'h2 && !q0_q.grd && !q1_q.grd) else $error("merge of lone store");
  a_merge_kinds: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    gif.merge |-> q0_q.kind == '0 && q1_q.kind == '0 && (q0_q.ci || q0_q.wt))
    else $error("excluded store merged");
  a_merge_beat: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    go_st && gif.merge && !st_ev |=> bus_valid && bus_we && bus_be == sgw_pkg::LINE_BE)
    else $error("merged pair not one full beat");
  a_wt_to_bus: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    go_st && q0_q.wt |=> bus_valid && bus_we && st_q == sgw_pkg::ST_WRITE)
    else $error("write-through store not on bus");
  a_wb_silent: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    wb_hit |=> !bus_valid && st_q == sgw_pkg::ST_IDLE) else $error("write-back hit went out");
  a_ci_no_alloc: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    (go_st && q0_q.ci) || (rd_dn && ld_op_q && ld_ci_q) |-> !(c_we && c_val))
    else $error("inhibited access allocated");
  a_snoop_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    snp_hold && !bus_dn |=> snp_hold && bus_valid && bus_we) else $error("snoop hold dropped");
  a_hold_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    snp_hold && bus_dn |=> !snp_hold && !mod_q[ev_idx_q]) else $error("copy-back left dirty");
  a_ld_waits: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    go_ldm |-> cnt_q == 2'h0 && !bus_valid) else $error("load miss passed pending store");
endmodule

// ### testbench/sgw_bus_mem.sv
// Bus memory partner: random request stalls, read answers after a fixed delay
`timescale 1ns/1ps
module sgw_bus_mem #(
  parameter int LAT = 40
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        bus_valid,
  input  wire logic        bus_we,
  input  wire logic [31:0] bus_addr,
  output logic             bus_ready,
  output logic             bus_rvalid,
  output logic [63:0]      bus_rdata
);
  logic        pend_q;
  logic [7:0]  cnt_q;
  logic [31:0] a_q;
  // Ready only for a held request; a read is answered LAT+1 cycles after acceptance
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      bus_ready  <= 1'h0;
      bus_rvalid <= 1'h0;
      bus_rdata  <= '1;
      pend_q     <= 1'h0;
      cnt_q      <= 8'h00;
      a_q        <= 32'h0;
    end
    else
    begin
      bus_ready  <= bus_valid && !bus_ready && !pend_q && $urandom_range(1) == 1;
      bus_rvalid <= pend_q && cnt_q == 8'h00;
      // Idle data line flips each cycle, so stale data never looks valid
      bus_rdata  <= (pend_q && cnt_q == 8'h00) ? {~a_q, a_q} : ~bus_rdata;
      if (bus_valid && bus_ready && !bus_we)
      begin
        pend_q <= 1'h1;
        cnt_q  <= 8'(LAT);
        a_q    <= bus_addr;
      end
      else if (pend_q)
      begin
        cnt_q  <= cnt_q - 8'h01;
        pend_q <= cnt_q != 8'h00;
      end
    end
endmodule

// ### testbench/sgw_top_tb.sv
// Self-checking bench: gathering cases, write-back, snoop copy-back, registers
`timescale 1ns/1ps
module sgw_top_tb;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, st_valid;
  logic st_ready, st_ci, st_wt, st_grd, ld_valid, ld_ci, ld_done, bus_valid, bus_ready, bus_we;
  logic bus_rvalid, snp_valid, snp_hold;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [3:0]   s_axi_wstrb, st_be;
  logic [4:0]   st_kind;
  logic [7:0]   bus_be;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, st_addr, st_data;
  logic [31:0]  ld_addr, ld_data, bus_addr, snp_addr, rd, a, d0, d1;
  logic [63:0]  bus_wdata, bus_rdata;
  logic [103:0] wq[$];
  int           failures, n_tests;
  sgw_top dut (.*);
  sgw_bus_mem mem (.*);
  // Clock and write monitor
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (bus_valid && bus_ready && bus_we) wq.push_back({bus_addr, bus_be, bus_wdata});
  task automatic chk(input logic [135:0] s, input logic [135:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // AXI4-Lite write then read back; both address and data are offered together
  task automatic axrw(input logic [31:0] ad, input logic [31:0] wd, input logic [1:0] e);
    logic aw_p;
    logic w_p;
    {aw_p, w_p} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {ad, wd, 2'h3};
    // Each channel is released on its own handshake; the slave may take them apart
    do
    begin
      @(posedge ref_clk);
      aw_p = aw_p && !s_axi_awready;
      w_p  = w_p && !s_axi_wready;
      s_axi_awvalid <= aw_p;
      s_axi_wvalid  <= w_p;
    end
    while (aw_p || w_p);
    s_axi_bready <= 1'h1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, e);
    {s_axi_bready, s_axi_araddr, s_axi_arvalid} <= {1'h0, ad, 1'h1};
    do @(posedge ref_clk); while (!s_axi_arready);
    {s_axi_arvalid, s_axi_rready} <= 2'h1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    chk(s_axi_rresp, e);
    s_axi_rready <= 1'h0;
  endtask
  task automatic st(input logic [31:0] ad, input logic [31:0] dt, input logic [7:0] att);
    {st_addr, st_data, st_ci, st_wt, st_grd, st_kind, st_valid} <= {ad, dt, att, 1'h1};
    do @(posedge ref_clk); while (!st_ready);
    st_valid <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Expected lone word write: word copied to both halves, lanes picked by bit 2
  function automatic logic [103:0] lone(input logic [31:0] ad, input logic [31:0] dt);
    lone = {ad, ad[2] ? 8'hF0 : 8'h0F, dt, dt};
  endfunction
  // Two stores queued together behind a slow load miss, higher word first
  task automatic gather(input logic store_gather_enable, input logic grd, input logic [4:0] k);
    logic c;
    c = 1'($urandom);
    a = {4'h1, 25'($urandom), 3'h0};
    {d0, d1} = {$urandom, $urandom};
    axrw(sgw_pkg::CFG_OFS, {31'h0, store_gather_enable}, sgw_pkg::RESP_OKAY);
    chk(rd, {31'h0, store_gather_enable});
    {ld_addr, ld_ci, ld_valid} <= {32'hF000_0000, 2'h3};
    @(posedge ref_clk);
    st(a + 32'h4, d1, {c, !c, grd, k});
    st(a, d0, {c, !c, grd, k});
    do @(posedge ref_clk); while (!ld_done);
    chk(ld_data, 32'hF000_0000);
    ld_valid <= 1'h0;
    repeat (60) @(posedge ref_clk);
    if (store_gather_enable && !grd && k == 5'h0) chk({wq.size(), wq[0]}, {32'h1, a, 8'hFF, d1, d0});
    else
    begin
      chk({wq.size(), wq[1]}, {32'h2, lone(a, d0)});
      chk(wq[0], lone(a + 32'h4, d1));
    end
    wq = {};
    $display("gather case %0d %0d %h done", store_gather_enable, grd, k);
  endtask
  initial
  begin
    {ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, st_valid, ld_valid, ld_ci, snp_valid, st_be, s_axi_wstrb} = {5'h0, 8'hFF};
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, st_addr, st_data, ld_addr, snp_addr} = '0;
    {st_ci, st_wt, st_grd, st_kind} = '0;
    void'($urandom(94));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'h1;
    axrw(32'h0000_000C, 32'h1, sgw_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    axrw(sgw_pkg::STAT_OFS, 32'h0, sgw_pkg::RESP_OKAY);
    chk(rd, 32'h4);
    $display("register case done");
    gather(1'h1, 1'h0, 5'h0);
    gather(1'h0, 1'h0, 5'h0);
    gather(1'h1, 1'h1, 5'h0);
    for (int i = 0; i < 5; i++) gather(1'h1, 1'h0, 5'h1 << i);
    axrw(sgw_pkg::MCNT_OFS, 32'h0, sgw_pkg::RESP_OKAY);
    chk(rd, 32'h1);
    // Write-back store stays in cache until a snoop asks for the line
    axrw(sgw_pkg::CFG_OFS, 32'h2, sgw_pkg::RESP_OKAY);
    chk(rd, 32'h2);
    a = {4'h2, 25'($urandom), 3'h0};
    st(a, d0, 8'h0);
    repeat (80) @(posedge ref_clk);
    chk(wq.size(), 0);
    {snp_addr, snp_valid} <= {a, 1'h1};
    do @(posedge ref_clk); while (!snp_hold);
    do @(posedge ref_clk); while (snp_hold);
    snp_valid <= 1'h0;
    chk({wq.size(), wq[0]}, {32'h1, a, 8'hFF, ~a, d0});
    $display("snoop case done");
    conclude();
  end
  initial
  begin
    // Tests need about 1000 cycles; twenty times that is a hang
    repeat (20000) @(posedge ref_clk);
    failures++;
    conclude();
  end
endmodule
